// ### design/uft_pkg.sv
// shared constants, types and helpers for the frame transmitter and its remote receiver
package uft_pkg;
  // register byte offsets on the software bus
  localparam logic [7:0] UFT_OFS_DATA = 8'h00;
  localparam logic [7:0] UFT_OFS_MODE = 8'h04;
  localparam logic [7:0] UFT_OFS_STATUS = 8'h08;
  localparam logic [7:0] UFT_OFS_CTRL = 8'h0C;
  localparam logic [7:0] UFT_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] UFT_OFS_IRQ_MASK = 8'h14;
  // data / divisor register fields
  localparam int UFT_DATA_LSB = 0;
  localparam int UFT_DATA_W = 9;
  localparam int UFT_DIV_LSB = 9;
  localparam int UFT_DIV_W = 7;
  // mode register fields
  localparam int UFT_MODE_LEN_LSB = 0;
  localparam int UFT_MODE_MSB_BIT = 2;
  localparam int UFT_MODE_INV_BIT = 3;
  localparam int UFT_MODE_PAR_LSB = 4;
  localparam int UFT_MODE_STOP2_BIT = 6;
  localparam int UFT_MODE_IRQSRC_BIT = 7;
  localparam int UFT_MODE_PRS_LSB = 8;
  localparam int UFT_PRS_W = 4;
  // status, control and interrupt bits
  localparam int UFT_ST_BUSY_BIT = 0;
  localparam int UFT_ST_BFF_BIT = 1;
  localparam int UFT_CTRL_LEVEL_BIT = 0;
  localparam int UFT_CTRL_OE_BIT = 1;
  localparam int UFT_CTRL_START_BIT = 2;
  localparam int UFT_CTRL_STOP_BIT = 3;
  localparam int UFT_IRQ_TX_BIT = 0;
  // reset values, counter widths, transfer code and data bit counts
  localparam logic [UFT_DIV_W-1:0] UFT_DIV_RST = 7'h02;
  localparam logic [UFT_DATA_W-1:0] UFT_DATA_RST = 9'h000;
  localparam logic UFT_LEVEL_RST = 1'b1;
  localparam int UFT_PRS_CNT_W = 15;
  localparam int UFT_BAUD_CNT_W = 8;
  localparam logic [1:0] UFT_HTRANS_NONSEQ = 2'h2;
  localparam logic [3:0] UFT_NBITS_7 = 4'h7;
  localparam logic [3:0] UFT_NBITS_8 = 4'h8;
  localparam logic [3:0] UFT_NBITS_9 = 4'h9;

  typedef enum logic [1:0] {
    UFT_LEN_7 = 2'b00,
    UFT_LEN_8 = 2'b01,
    UFT_LEN_9 = 2'b10
  } uft_len_t;

  typedef enum logic [1:0] {
    UFT_PAR_NONE = 2'b00,
    UFT_PAR_ZERO = 2'b01,
    UFT_PAR_EVEN = 2'b10,
    UFT_PAR_ODD = 2'b11
  } uft_par_t;

  typedef enum logic [2:0] {
    UFT_ST_IDLE = 3'b000,
    UFT_ST_START = 3'b001,
    UFT_ST_DATA = 3'b010,
    UFT_ST_PARITY = 3'b011,
    UFT_ST_STOP = 3'b100
  } uft_state_t;

  // number of data bits for a length code; code 11 acts as eight
  function automatic logic [3:0] uft_nbits(input logic [1:0] len, input logic nine_ok);
    logic [3:0] n;
    n = UFT_NBITS_8;
    if (len == UFT_LEN_7) begin
      n = UFT_NBITS_7;
    end else if (len == UFT_LEN_9 && nine_ok) begin
      n = UFT_NBITS_9;
    end
    return n;
  endfunction

  // parity bit over the valid data bits
  function automatic logic uft_parity(input logic [1:0] par, input logic [8:0] d, input logic [3:0] n);
    logic [8:0] m;
    logic p;
    m = d & ~(9'h1FF << n);
    p = 1'b0;
    if (par == UFT_PAR_EVEN) begin
      p = ^m;
    end else if (par == UFT_PAR_ODD) begin
      p = ~(^m);
    end
    return p;
  endfunction

  // position of the idx-th bit on the line for the chosen order
  function automatic logic [3:0] uft_bitpos(input logic msb, input logic [3:0] idx, input logic [3:0] n);
    return msb ? 4'(n - 4'h1 - idx) : idx;
  endfunction
endpackage

// ### design/uft_if.sv
// serial line between the frame transmitter and the remote receiver
`timescale 1ns/1ns
`default_nettype none
interface uft_if;
  logic serial_tx_pin; // transmit line level
  modport tx_mp (output serial_tx_pin);
  modport rx_mp (input serial_tx_pin);
endinterface
`default_nettype wire

// ### design/uft_transmitter.sv
// frame transmitter channel with ahb-lite register slave
//
// Overview of operation
// RULE_01 - send start, data, parity, stop at baud
// RULE_02 - even channel transmits, odd receives
// RULE_03 - seven, eight or nine data bits
// RULE_04 - selectable msb or lsb first
// RULE_05 - inversion option; idle high or low
// RULE_06 - parity none, zero, even or odd
// RULE_07 - one or two stop bits
// RULE_08 - software sets divisor at least two
// RULE_09 - irq at frame end or buffer empty
// RULE_10 - write while full overwrites held data
// RULE_11 - software changes irq mode before last bit
// RULE_12 - software presets output level before start
// RULE_13 - software sets only target channel bits
// RULE_14 - channel pair serves only uart function
// RULE_15 - reinitialise after clock supply switched off
// RULE_16 - start active low, stop idle, one period
`timescale 1ns/1ns
`default_nettype none
module uft_transmitter
  import uft_pkg::*;
#(
  parameter bit NINE_BIT_OK = 1'b1 // nine-bit length allowed on this instance
) (
  input wire logic clock, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [7:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write access
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // response, always okay
  output logic [31:0] hrdata, // read data
  output logic tx_irq, // level interrupt
  uft_if.tx_mp link // serial line
);
  logic [UFT_DATA_W-1:0] tx_data_reg;
  logic [UFT_DIV_W-1:0] divisor_reg;
  logic buffer_full_flag;
  logic [1:0] len_reg;
  logic msb_first_reg;
  logic level_invert_select;
  logic [1:0] parity_reg;
  logic stop2_reg;
  logic irq_source_select;
  logic [UFT_PRS_W-1:0] prescale_reg;
  logic output_level_reg;
  logic output_enable_reg;
  logic channel_start_reg;
  logic irq_stat_reg;
  logic irq_mask_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  uft_state_t state_reg;
  logic [UFT_DATA_W-1:0] shift_reg;
  logic [3:0] bit_idx_reg;
  logic stop_idx_reg;
  logic [UFT_PRS_CNT_W-1:0] prs_cnt_reg;
  logic [UFT_BAUD_CNT_W-1:0] baud_cnt_reg;

  logic addr_phase;
  logic wr_data, wr_mode, wr_ctrl, wr_istat, wr_imask;
  logic start_wr, stop_wr, level_wr;
  logic tick, bit_end, frame_done, load, tx_event;
  logic [3:0] nbits;
  logic [UFT_PRS_CNT_W-1:0] prs_top;
  logic [UFT_BAUD_CNT_W-1:0] baud_top;
  logic line_bit;
  logic [31:0] rd_mux;

  // bus decode; writes land in the data phase
  assign addr_phase = hsel && hready && htrans == UFT_HTRANS_NONSEQ;
  assign wr_data = wr_pend_reg && wr_addr_reg == UFT_OFS_DATA;
  assign wr_mode = wr_pend_reg && wr_addr_reg == UFT_OFS_MODE;
  assign wr_ctrl = wr_pend_reg && wr_addr_reg == UFT_OFS_CTRL;
  assign wr_istat = wr_pend_reg && wr_addr_reg == UFT_OFS_IRQ_STAT;
  assign wr_imask = wr_pend_reg && wr_addr_reg == UFT_OFS_IRQ_MASK;
  assign start_wr = wr_ctrl && hwdata[UFT_CTRL_START_BIT]; // [RULE_13]
  assign stop_wr = wr_ctrl && hwdata[UFT_CTRL_STOP_BIT];
  assign level_wr = wr_ctrl && state_reg == UFT_ST_IDLE; // [RULE_12]

  // prescaler picks the channel operation clock, a power of two of the system clock
  assign prs_top = UFT_PRS_CNT_W'((16'h1 << prescale_reg) - 16'h1);
  assign tick = prs_cnt_reg == prs_top;
  // one bit lasts 2*(divisor+1) operation clocks; divisor below two is unsupported [RULE_08]
  assign baud_top = {1'b0, divisor_reg} * 8'h02 + 8'h01;
  assign bit_end = tick && baud_cnt_reg == baud_top; // [RULE_16]
  assign nbits = uft_nbits(len_reg, NINE_BIT_OK); // [RULE_03]
  assign frame_done = state_reg == UFT_ST_STOP && bit_end && (stop_idx_reg || !stop2_reg); // [RULE_07]
  // back-to-back frames load straight from the stop bit, no idle gap
  assign load = channel_start_reg && buffer_full_flag && (state_reg == UFT_ST_IDLE || frame_done);
  // buffer empty in continuous mode, frame end in single mode [RULE_09] [RULE_11]
  assign tx_event = irq_source_select ? load : (frame_done && !load);

  // logical level for the current state, before inversion
  always_comb begin
    line_bit = 1'b1;
    unique case (state_reg)
      UFT_ST_IDLE: line_bit = 1'b1;
      UFT_ST_START: line_bit = 1'b0; // [RULE_16]
      UFT_ST_DATA: line_bit = shift_reg[uft_bitpos(msb_first_reg, bit_idx_reg, nbits)]; // [RULE_04]
      UFT_ST_PARITY: line_bit = uft_parity(parity_reg, shift_reg, nbits); // [RULE_06]
      UFT_ST_STOP: line_bit = 1'b1; // [RULE_16]
      default: line_bit = 1'b1;
    endcase
  end

  // register read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr)
      UFT_OFS_DATA: rd_mux = {16'h0000, divisor_reg, tx_data_reg};
      UFT_OFS_MODE: rd_mux = {20'h00000, prescale_reg, irq_source_select, stop2_reg, parity_reg,
        level_invert_select, msb_first_reg, len_reg};
      UFT_OFS_STATUS: rd_mux = {30'h0000_0000, buffer_full_flag, state_reg != UFT_ST_IDLE};
      UFT_OFS_CTRL: rd_mux = {29'h0000_0000, channel_start_reg, output_enable_reg, output_level_reg};
      UFT_OFS_IRQ_STAT: rd_mux = {31'h0000_0000, irq_stat_reg};
      UFT_OFS_IRQ_MASK: rd_mux = {31'h0000_0000, irq_mask_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // bus slave: zero wait states, read data from a flop
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      wr_addr_reg <= haddr;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_phase && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // mode settings; the channel is a fixed uart transmitter, other functions absent [RULE_14] [RULE_02]
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      len_reg <= UFT_LEN_8;
      msb_first_reg <= 1'b0;
      level_invert_select <= 1'b0;
      parity_reg <= UFT_PAR_NONE;
      stop2_reg <= 1'b0;
      irq_source_select <= 1'b0;
      prescale_reg <= 4'h0;
    end else if (wr_mode) begin
      len_reg <= hwdata[UFT_MODE_LEN_LSB +: 2];
      msb_first_reg <= hwdata[UFT_MODE_MSB_BIT];
      level_invert_select <= hwdata[UFT_MODE_INV_BIT];
      parity_reg <= hwdata[UFT_MODE_PAR_LSB +: 2];
      stop2_reg <= hwdata[UFT_MODE_STOP2_BIT];
      irq_source_select <= hwdata[UFT_MODE_IRQSRC_BIT];
      prescale_reg <= hwdata[UFT_MODE_PRS_LSB +: UFT_PRS_W];
    end
  end

  // data buffer; a write while full simply replaces the held word [RULE_10]
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_data_reg <= UFT_DATA_RST;
      divisor_reg <= UFT_DIV_RST;
      buffer_full_flag <= 1'b0;
    end else begin
      if (wr_data) begin
        tx_data_reg <= hwdata[UFT_DATA_LSB +: UFT_DATA_W];
        divisor_reg <= hwdata[UFT_DIV_LSB +: UFT_DIV_W];
      end
      // a new write wins over the load that empties the buffer
      if (wr_data) begin
        buffer_full_flag <= 1'b1;
      end else if (load) begin
        buffer_full_flag <= 1'b0;
      end
    end
  end

  // channel control bits
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      output_enable_reg <= 1'b0;
      channel_start_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        output_enable_reg <= hwdata[UFT_CTRL_OE_BIT];
      end
      if (stop_wr) begin
        channel_start_reg <= 1'b0;
      end else if (start_wr) begin
        channel_start_reg <= 1'b1;
      end
    end
  end

  // line level: software preset while idle, then follows the data [RULE_05] [RULE_12]
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      output_level_reg <= UFT_LEVEL_RST;
    end else if (level_wr) begin
      output_level_reg <= hwdata[UFT_CTRL_LEVEL_BIT];
    end else if (output_enable_reg && state_reg != UFT_ST_IDLE) begin
      output_level_reg <= line_bit ^ level_invert_select; // [RULE_05]
    end else if (output_enable_reg && channel_start_reg) begin
      output_level_reg <= level_invert_select ? 1'b0 : 1'b1; // [RULE_05]
    end
  end
  assign link.serial_tx_pin = output_level_reg;

  // baud timing; counters restart with each frame so bit edges are exact
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prs_cnt_reg <= '0;
      baud_cnt_reg <= '0;
    end else if (load || state_reg == UFT_ST_IDLE) begin
      prs_cnt_reg <= '0;
      baud_cnt_reg <= '0;
    end else begin
      prs_cnt_reg <= tick ? '0 : prs_cnt_reg + 1'b1;
      if (bit_end) begin
        baud_cnt_reg <= '0;
      end else if (tick) begin
        baud_cnt_reg <= baud_cnt_reg + 1'b1;
      end
    end
  end

  // frame sequencer [RULE_01]
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= UFT_ST_IDLE;
      shift_reg <= '0;
      bit_idx_reg <= 4'h0;
      stop_idx_reg <= 1'b0;
    end else if (stop_wr) begin
      state_reg <= UFT_ST_IDLE;
    end else if (load) begin
      state_reg <= UFT_ST_START;
      shift_reg <= tx_data_reg;
      bit_idx_reg <= 4'h0;
      stop_idx_reg <= 1'b0;
    end else if (bit_end) begin
      unique case (state_reg)
        UFT_ST_START: state_reg <= UFT_ST_DATA;
        UFT_ST_DATA: begin
          bit_idx_reg <= bit_idx_reg + 4'h1;
          if (bit_idx_reg == nbits - 4'h1) begin
            state_reg <= parity_reg == UFT_PAR_NONE ? UFT_ST_STOP : UFT_ST_PARITY; // [RULE_06]
          end
        end
        UFT_ST_PARITY: state_reg <= UFT_ST_STOP;
        UFT_ST_STOP: begin
          stop_idx_reg <= 1'b1;
          if (frame_done) begin
            state_reg <= UFT_ST_IDLE; // [RULE_07]
          end
        end
        default: state_reg <= UFT_ST_IDLE;
      endcase
    end
  end

  // sticky interrupt, set wins over a write-one clear [RULE_09]
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_stat_reg <= 1'b0;
      irq_mask_reg <= 1'b0;
      tx_irq <= 1'b0;
    end else begin
      if (tx_event) begin
        irq_stat_reg <= 1'b1;
      end else if (wr_istat && hwdata[UFT_IRQ_TX_BIT]) begin
        irq_stat_reg <= 1'b0;
      end
      if (wr_imask) begin
        irq_mask_reg <= hwdata[UFT_IRQ_TX_BIT];
      end
      tx_irq <= irq_stat_reg && irq_mask_reg;
    end
  end
endmodule
`default_nettype wire

// ### design/uft_receiver.sv
// remote asynchronous receiver on the odd channel side of the line
`timescale 1ns/1ns
`default_nettype none
module uft_receiver
  import uft_pkg::*;
#(
  parameter int CYC_W = 24 // width of the bit period count
) (
  input wire logic clock, // system clock
  input wire logic rstn, // async reset, active low
  uft_if.rx_mp link, // serial line
  input wire logic [1:0] cfg_len, // length code
  input wire logic [1:0] cfg_parity, // parity code
  input wire logic cfg_msb_first, // msb first order
  input wire logic cfg_invert, // line inverted
  input wire logic [CYC_W-1:0] cfg_bit_cycles, // clocks per bit, at least 2
  output logic [8:0] rx_data, // received word
  output logic rx_valid, // one-cycle pulse per frame
  output logic rx_parity_err, // parity mismatch of last frame
  output logic rx_frame_err // stop bit low in last frame
);
  uft_state_t state_reg;
  logic [CYC_W-1:0] cnt_reg;
  logic [3:0] idx_reg;
  logic [8:0] word_reg;
  logic line;
  logic [3:0] nbits;
  logic sample;

  // receiver sees the line after undoing inversion; one stop bit checked
  assign line = link.serial_tx_pin ^ cfg_invert;
  assign nbits = uft_nbits(cfg_len, 1'b1);
  assign sample = cnt_reg == '0;

  // frame receive: start edge, mid-bit sampling
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= UFT_ST_IDLE;
      cnt_reg <= '0;
      idx_reg <= 4'h0;
      word_reg <= 9'h000;
      rx_data <= 9'h000;
      rx_valid <= 1'b0;
      rx_parity_err <= 1'b0;
      rx_frame_err <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!sample) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
      unique case (state_reg)
        UFT_ST_IDLE: if (!line) begin
          state_reg <= UFT_ST_START;
          cnt_reg <= (cfg_bit_cycles >> 1) - 1'b1;
        end
        UFT_ST_START: if (sample) begin
          state_reg <= line ? UFT_ST_IDLE : UFT_ST_DATA;
          cnt_reg <= cfg_bit_cycles - 1'b1;
          idx_reg <= 4'h0;
          word_reg <= 9'h000;
        end
        UFT_ST_DATA: if (sample) begin
          word_reg[uft_bitpos(cfg_msb_first, idx_reg, nbits)] <= line;
          idx_reg <= idx_reg + 4'h1;
          cnt_reg <= cfg_bit_cycles - 1'b1;
          if (idx_reg == nbits - 4'h1) begin
            state_reg <= cfg_parity == UFT_PAR_NONE ? UFT_ST_STOP : UFT_ST_PARITY;
          end
        end
        UFT_ST_PARITY: if (sample) begin
          rx_parity_err <= line != uft_parity(cfg_parity, word_reg, nbits);
          cnt_reg <= cfg_bit_cycles - 1'b1;
          state_reg <= UFT_ST_STOP;
        end
        UFT_ST_STOP: if (sample) begin
          if (cfg_parity == UFT_PAR_NONE) begin
            rx_parity_err <= 1'b0;
          end
          rx_frame_err <= !line;
          rx_data <= word_reg;
          rx_valid <= 1'b1;
          state_reg <= UFT_ST_IDLE;
        end
        default: state_reg <= UFT_ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### testbench/uft_assertions.sv
// concurrent checks on the serial line, the bus response and the receiver flags
`timescale 1ns/1ns
`default_nettype none
module uft_assertions (
  input wire logic clock, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic serial_tx_pin, // transmit line
  input wire logic hreadyout, // slave ready
  input wire logic hresp, // slave response
  input wire logic tx_irq, // level interrupt
  input wire logic rx_valid, // frame received pulse
  input wire logic rx_parity_err, // parity mismatch
  input wire logic rx_frame_err // stop bit low
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // zero wait states and okay on every cycle, reads and writes alike
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("bus ready dropped");
  // line idles high and no interrupt straight after reset
  a_reset_idle: assert property ($rose(rstn) |-> serial_tx_pin && !tx_irq)
    else $error("line or interrupt wrong after reset");
  // every level on the line lasts at least one six-clock bit period
  a_pin_hold: assert property ($changed(serial_tx_pin) |=> $stable(serial_tx_pin) [*5])
    else $error("line level shorter than one bit");
  // the receiver sees a proper stop bit and matching parity
  a_stop_level: assert property (rx_valid |-> !rx_frame_err)
    else $error("stop bit not at idle level");
  a_parity_ok: assert property (rx_valid |-> !rx_parity_err)
    else $error("parity bit wrong");
  // no frame pulse within the eight clocks that follow another
  a_valid_spacing: assert property (rx_valid |=> !rx_valid [*8])
    else $error("frames too close together");
  a_valid_mid_stop: assert property (rx_valid |-> $stable(serial_tx_pin))
    else $error("line moved in mid stop bit");
endmodule
`default_nettype wire

// ### testbench/uft_transmitter_bench.sv
// self-checking bench: register bus, transmitter and remote receiver face to face
`timescale 1ns/1ns
`default_nettype none
module uft_transmitter_bench;
  import uft_pkg::*;
  localparam logic [7:0] mode_tab [6] = '{8'h00, 8'h5D, 8'h22, 8'h3E, 8'h71, 8'h26};
  logic clock, rstn, hsel, hwrite;
  logic [7:0] haddr;
  logic [1:0] htrans, cfg_len, cfg_parity;
  logic [2:0] hsize;
  logic [31:0] hwdata, rd;
  logic cfg_msb_first, cfg_invert;
  logic [23:0] cfg_bit_cycles;
  wire logic hreadyout, hresp, tx_irq, rx_valid, rx_parity_err, rx_frame_err;
  wire logic [31:0] hrdata;
  wire logic [8:0] rx_data;
  int mismatches = 0, checks = 0, cycles = 0, rx_count = 0;
  logic [31:0] exp_q[$];
  int t_q[$];

  uft_if uft_if_i ();
  uft_transmitter uft_transmitter_i (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .tx_irq(tx_irq), .link(uft_if_i));
  uft_receiver uft_receiver_i (.clock(clock), .rstn(rstn), .link(uft_if_i), .cfg_len(cfg_len),
    .cfg_parity(cfg_parity), .cfg_msb_first(cfg_msb_first), .cfg_invert(cfg_invert),
    .cfg_bit_cycles(cfg_bit_cycles), .rx_data(rx_data), .rx_valid(rx_valid), .rx_parity_err(rx_parity_err),
    .rx_frame_err(rx_frame_err));
  uft_assertions uft_assertions_i (.clock(clock), .rstn(rstn), .serial_tx_pin(uft_if_i.serial_tx_pin),
    .hreadyout(hreadyout), .hresp(hresp), .tx_irq(tx_irq), .rx_valid(rx_valid),
    .rx_parity_err(rx_parity_err), .rx_frame_err(rx_frame_err));

  // 250 mhz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic end_of_test();
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single transfer; no wait count assumed, only the timeout ends a hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= UFT_HTRANS_NONSEQ;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask

  task automatic wait_rx(input int n);
    while (rx_count < n) @(posedge clock);
  endtask

  // one configuration: a frame, a held word overwritten, then the gap between frames
  task automatic run_cfg(input logic [7:0] m, input int div);
    int n, fl, base;
    logic [31:0] d[3];
    n = 7 + int'(m[1:0]);
    fl = (2 + n + int'(m[5:4] != 2'h0) + int'(m[6])) * 2 * (div + 1);
    base = rx_count;
    bus(1'b1, UFT_OFS_MODE, {24'h0, m});
    // receiver switches at the edge where the idle level flips, else it sees a false start
    @(posedge clock);
    cfg_len <= m[1:0];
    cfg_msb_first <= m[2];
    cfg_invert <= m[3];
    cfg_parity <= m[5:4];
    cfg_bit_cycles <= 24'(2 * (div + 1));
    bus(1'b1, UFT_OFS_CTRL, {29'h0, 2'b11, ~m[3]});
    repeat (8) @(posedge clock);
    cmp({31'h0, uft_if_i.serial_tx_pin}, {31'h0, ~m[3]});
    for (int k = 0; k < 3; k++) begin
      d[k] = $urandom & 32'h1FF;
      bus(1'b1, UFT_OFS_DATA, d[k] | (32'(div) << 9));
      if (k == 0) begin
        // middle of the first data bit, read off the line so bit order is judged apart from the receiver
        repeat (3 + 3 * (div + 1)) @(posedge clock);
        cmp({31'h0, uft_if_i.serial_tx_pin}, {31'h0, (m[2] ? d[0][n - 1] : d[0][0]) ^ m[3]});
      end
    end
    rchk(UFT_OFS_STATUS, 32'h3);
    exp_q.push_back(d[0] & ((32'h1 << n) - 32'h1));
    exp_q.push_back(d[2] & ((32'h1 << n) - 32'h1));
    wait_rx(base + 2);
    cmp(32'(t_q[$] - t_q[$ - 1]), 32'(fl));
    do bus(1'b0, UFT_OFS_STATUS, 32'h0); while (rd !== 32'h0);
    rchk(UFT_OFS_IRQ_STAT, 32'h1);
    cmp({31'h0, tx_irq}, 32'h0);
    bus(1'b1, UFT_OFS_IRQ_STAT, 32'h1);
    rchk(UFT_OFS_IRQ_STAT, 32'h0);
  endtask

  // timeout and cycle count
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  // reference model: each received word against the queue of words written
  always @(posedge clock) begin
    if (rx_valid === 1'b1) begin
      t_q.push_back(cycles);
      rx_count++;
      cmp({23'h0, rx_data}, exp_q.size() > 0 ? exp_q.pop_front() : 32'hFFFFFFFF);
    end
  end

  initial begin
    {hsel, hwrite, haddr, htrans, hwdata, cfg_parity, cfg_msb_first, cfg_invert} = '0;
    hsize = 3'h2;
    cfg_len = 2'h1;
    cfg_bit_cycles = 24'h6;
    rstn = 1'b0;
    void'($urandom(21));
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    rchk(UFT_OFS_MODE, 32'h1);
    rchk(UFT_OFS_DATA, 32'h400);
    rchk(UFT_OFS_CTRL, 32'h1);
    rchk(UFT_OFS_IRQ_MASK, 32'h0);
    bus(1'b1, 8'h20, 32'hFFFFFFFF);
    rchk(8'h20, 32'h0);
    cmp({31'h0, uft_if_i.serial_tx_pin}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      run_cfg(mode_tab[i], (i == 4) ? 3 : 2);
    end
    // clock supply cut while idle: a full reset stands for the reinitialisation
    @(posedge clock);
    rstn <= 1'b0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    rchk(UFT_OFS_CTRL, 32'h1);
    // buffer-empty mode: event at load, unmasked, then cleared mid-frame
    bus(1'b1, UFT_OFS_IRQ_MASK, 32'h1);
    bus(1'b1, UFT_OFS_CTRL, 32'h7);
    @(posedge clock);
    cfg_len <= 2'h1;
    cfg_parity <= 2'h0;
    cfg_msb_first <= 1'b0;
    bus(1'b1, UFT_OFS_MODE, 32'h81);
    exp_q.push_back($urandom & 32'hFF);
    bus(1'b1, UFT_OFS_DATA, exp_q[$] | 32'h400);
    rchk(UFT_OFS_IRQ_STAT, 32'h1);
    cmp({31'h0, tx_irq}, 32'h1);
    bus(1'b1, UFT_OFS_IRQ_STAT, 32'h1);
    rchk(UFT_OFS_STATUS, 32'h1);
    cmp({31'h0, tx_irq}, 32'h0);
    wait_rx(13);
    // stop after the last frame: channel leaves started, line keeps its idle level
    bus(1'b1, UFT_OFS_CTRL, 32'hB);
    rchk(UFT_OFS_CTRL, 32'h3);
    end_of_test();
  end
endmodule
`default_nettype wire
